//--- hdl/down_counter_pkg.sv
package down_counter_pkg;
  // byte port offsets on the i/o bus
  localparam logic [2:0] OFF_COUNTER0_DATA = 3'h4;
  localparam logic [2:0] OFF_COUNTER1_DATA = 3'h5;
  localparam logic [2:0] OFF_COUNTER2_DATA = 3'h6;
  localparam logic [2:0] OFF_COUNTER_CONTROL_WORD = 3'h7;
  // control word fields
  localparam int CW_SEL_MSB = 7;
  localparam int CW_SEL_LSB = 6;
  localparam int CW_FMT_MSB = 5;
  localparam int CW_FMT_LSB = 4;
  localparam int CW_MODE_MSB = 3;
  localparam int CW_MODE_LSB = 1;
  localparam int CW_BCD_BIT = 0;
  localparam logic [1:0] SEL_ILLEGAL = 2'h3;
  localparam int NUM_COUNTERS = 3;
  // access formats
  localparam logic [1:0] FMT_LATCH = 2'h0;
  localparam logic [1:0] FMT_LOW = 2'h1;
  localparam logic [1:0] FMT_HIGH = 2'h2;
  localparam logic [1:0] FMT_LOW_HIGH = 2'h3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [2:0] MODE_RESET = 3'h0;
  // counting behaviours
  typedef enum logic [2:0] {
    M_TERMINAL = 3'b000,
    M_ONE_SHOT = 3'b001,
    M_RATE = 3'b010,
    M_SQUARE = 3'b011,
    M_SW_STROBE = 3'b100,
    M_HW_STROBE = 3'b101
  } count_mode_t;
  // internal 1 MHz source for counter two
  localparam int REF_CLK_HZ = 20000000;
  localparam int CNT2_CLK_HZ = 1000000;
  localparam int CNT2_DIV = REF_CLK_HZ / CNT2_CLK_HZ;
  localparam logic [4:0] CNT2_DIV_LAST = 5'(CNT2_DIV - 1);
endpackage : down_counter_pkg

//--- hdl/count_chan_if.sv
`timescale 1ns/1ns
interface count_chan_if;
  import down_counter_pkg::*;
  logic load;
  logic [15:0] load_val;
  logic [2:0] mode_field;
  logic bcd;
  logic tick;
  logic gate;
  logic [15:0] count;
  logic out_lvl;
  modport ctrl (output load, load_val, mode_field, bcd, tick, gate,
                input count, out_lvl);
  modport core (input load, load_val, mode_field, bcd, tick, gate,
                output count, out_lvl);
endinterface : count_chan_if

//--- hdl/down_count_core.sv
`timescale 1ns/1ns
module down_count_core
  import down_counter_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // channel
  count_chan_if.core ch
);
  logic [15:0] cnt_reg, cnt_next, reload_reg, reload_next;
  logic out_reg, out_next, run_reg, run_next;
  logic gate_d_reg, gate_d_next, trig_reg, trig_next;
  count_mode_t mode;

  function automatic logic [15:0] dec(input logic [15:0] v, input logic b);
    logic [15:0] r;
    r = v - COUNT_ONE;
    if (b)
    begin
      r = v;
      for (int i = 0; i < 4; i++)
      begin
        if (r[i*4 +: 4] != 4'h0)
        begin
          r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
          break;
        end
        r[i*4 +: 4] = 4'h9;
      end
    end
    return r;
  endfunction : dec

  always_comb
  begin
    if (ch.mode_field[1])
      mode = count_mode_t'({1'b0, ch.mode_field[1:0]});
    else
      mode = count_mode_t'(ch.mode_field);
  end

  always_comb
  begin
    cnt_next = cnt_reg;
    reload_next = reload_reg;
    out_next = out_reg;
    run_next = run_reg;
    gate_d_next = ch.gate;
    trig_next = trig_reg;
    // gate rising edge waits for the next count clock
    if (ch.tick)
      trig_next = 1'b0;
    if (ch.gate && !gate_d_reg)
      trig_next = 1'b1;
    if (ch.load)
    begin
      reload_next = ch.load_val;
      cnt_next = ch.load_val;
      trig_next = 1'b0;
      out_next = (mode != M_TERMINAL);
      run_next = (mode == M_TERMINAL) || (mode == M_SW_STROBE)
                 || (mode == M_RATE) || (mode == M_SQUARE);
      if (mode == M_SQUARE)
        cnt_next = 16'((17'(ch.load_val) + 17'h1) >> 1);
    end
    else if (ch.tick)
    begin
      case (mode)
        M_TERMINAL:
        begin
          if (run_reg && ch.gate)
          begin
            cnt_next = dec(cnt_reg, ch.bcd);
            if (cnt_reg == COUNT_ONE)
            begin
              out_next = 1'b1;
              run_next = 1'b0;
            end
          end
        end
        M_ONE_SHOT, M_HW_STROBE:
        begin
          if (trig_reg)
          begin
            cnt_next = reload_reg;
            run_next = 1'b1;
            out_next = (mode == M_HW_STROBE);
          end
          else if (run_reg)
          begin
            cnt_next = dec(cnt_reg, ch.bcd);
            out_next = (mode == M_HW_STROBE) ? 1'b1 : 1'b0;
            if (cnt_reg == COUNT_ONE)
            begin
              out_next = (mode == M_ONE_SHOT);
              run_next = 1'b0;
            end
          end
          else
            out_next = 1'b1;
        end
        M_RATE:
        begin
          if (trig_reg)
            cnt_next = reload_reg;
          else if (ch.gate)
          begin
            out_next = (cnt_reg != COUNT_ONE);
            cnt_next = (cnt_reg == COUNT_ONE) ? reload_reg
                                              : dec(cnt_reg, ch.bcd);
          end
          else
            out_next = 1'b1;
        end
        M_SQUARE:
        begin
          if (trig_reg)
          begin
            cnt_next = 16'((17'(reload_reg) + 17'h1) >> 1);
            out_next = 1'b1;
          end
          else if (ch.gate)
          begin
            if (cnt_reg == COUNT_ONE)
            begin
              out_next = !out_reg;
              cnt_next = out_reg ? (reload_reg >> 1)
                       : 16'((17'(reload_reg) + 17'h1) >> 1);
            end
            else
              cnt_next = dec(cnt_reg, ch.bcd);
          end
        end
        M_SW_STROBE:
        begin
          out_next = 1'b1;
          if (run_reg && ch.gate)
          begin
            cnt_next = dec(cnt_reg, ch.bcd);
            if (cnt_reg == COUNT_ONE)
            begin
              out_next = 1'b0;
              run_next = 1'b0;
            end
          end
        end
        default:
          out_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= COUNT_ZERO;
      reload_reg <= COUNT_ZERO;
      out_reg <= 1'b1;
      run_reg <= 1'b0;
      gate_d_reg <= 1'b0;
      trig_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      reload_reg <= reload_next;
      out_reg <= out_next;
      run_reg <= run_next;
      gate_d_reg <= gate_d_next;
      trig_reg <= trig_next;
    end
  end

  assign ch.count = cnt_reg;
  assign ch.out_lvl = out_reg;
endmodule : down_count_core

//--- hdl/triple_down_counter_timer.sv
`timescale 1ns/1ns
module triple_down_counter_timer
  import down_counter_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // i/o bus byte port
  input wire logic [2:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // counter pins
  input wire logic count_clk0,
  input wire logic count_clk1,
  input wire logic gate0,
  input wire logic gate1,
  input wire logic gate2,
  output logic count_out0,
  output logic count_out1,
  output logic count_out2
);
  count_chan_if ch[NUM_COUNTERS]();

  logic [1:0] fmt_reg[NUM_COUNTERS], fmt_next[NUM_COUNTERS];
  logic [2:0] mode_reg[NUM_COUNTERS], mode_next[NUM_COUNTERS];
  logic bcd_reg[NUM_COUNTERS], bcd_next[NUM_COUNTERS];
  logic wr_hi_reg[NUM_COUNTERS], wr_hi_next[NUM_COUNTERS];
  logic rd_hi_reg[NUM_COUNTERS], rd_hi_next[NUM_COUNTERS];
  logic [7:0] low_hold_reg[NUM_COUNTERS], low_hold_next[NUM_COUNTERS];
  logic [15:0] latch_reg[NUM_COUNTERS], latch_next[NUM_COUNTERS];
  logic held_reg[NUM_COUNTERS], held_next[NUM_COUNTERS];
  logic load_pls[NUM_COUNTERS];
  logic [15:0] load_val[NUM_COUNTERS];
  logic [15:0] live[NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0] outs;
  logic [7:0] rdata_reg, rdata_next;
  logic [4:0] div_reg, div_next;
  logic tick2_reg, tick2_next;
  logic clk0_d_reg, clk1_d_reg;
  logic [NUM_COUNTERS-1:0] gates;
  logic [NUM_COUNTERS-1:0] ticks;
  logic [1:0] cw_sel;
  logic [1:0] data_idx;
  logic data_hit;

  assign cw_sel = io_wdata[CW_SEL_MSB:CW_SEL_LSB];
  assign gates = {gate2, gate1, gate0};
  // counter two on internal 1 MHz enable
  assign ticks = {tick2_reg, count_clk1 & ~clk1_d_reg,
                  count_clk0 & ~clk0_d_reg};

  always_comb
  begin
    data_hit = 1'b1;
    data_idx = 2'h0;
    case (io_addr)
      OFF_COUNTER0_DATA: data_idx = 2'h0;
      OFF_COUNTER1_DATA: data_idx = 2'h1;
      OFF_COUNTER2_DATA: data_idx = 2'h2;
      default: data_hit = 1'b0;
    endcase
  end

  // divider for the 1 MHz count clock
  always_comb
  begin
    div_next = (div_reg == CNT2_DIV_LAST) ? 5'h00 : div_reg + 5'h01;
    tick2_next = (div_reg == CNT2_DIV_LAST);
  end

  always_comb
  begin
    rdata_next = rdata_reg;
    for (int i = 0; i < NUM_COUNTERS; i++)
    begin
      fmt_next[i] = fmt_reg[i];
      mode_next[i] = mode_reg[i];
      bcd_next[i] = bcd_reg[i];
      wr_hi_next[i] = wr_hi_reg[i];
      rd_hi_next[i] = rd_hi_reg[i];
      low_hold_next[i] = low_hold_reg[i];
      latch_next[i] = latch_reg[i];
      held_next[i] = held_reg[i];
      load_pls[i] = 1'b0;
      load_val[i] = COUNT_ZERO;
      if (io_wr && io_addr == OFF_COUNTER_CONTROL_WORD
          && cw_sel != SEL_ILLEGAL && cw_sel == 2'(i))
      begin
        if (io_wdata[CW_FMT_MSB:CW_FMT_LSB] == FMT_LATCH)
        begin
          if (!held_reg[i])
          begin
            latch_next[i] = live[i];
            held_next[i] = 1'b1;
          end
        end
        else
        begin
          fmt_next[i] = io_wdata[CW_FMT_MSB:CW_FMT_LSB];
          mode_next[i] = io_wdata[CW_MODE_MSB:CW_MODE_LSB];
          bcd_next[i] = io_wdata[CW_BCD_BIT];
          wr_hi_next[i] = 1'b0;
          rd_hi_next[i] = 1'b0;
          held_next[i] = 1'b0;
        end
      end
      if (io_wr && data_hit && data_idx == 2'(i))
      begin
        case (fmt_reg[i])
          FMT_LOW:
          begin
            load_pls[i] = 1'b1;
            load_val[i] = {BYTE_ZERO, io_wdata};
          end
          FMT_HIGH:
          begin
            load_pls[i] = 1'b1;
            load_val[i] = {io_wdata, BYTE_ZERO};
          end
          FMT_LOW_HIGH:
          begin
            wr_hi_next[i] = !wr_hi_reg[i];
            if (wr_hi_reg[i])
            begin
              load_pls[i] = 1'b1;
              load_val[i] = {io_wdata, low_hold_reg[i]};
            end
            else
              low_hold_next[i] = io_wdata;
          end
          default:
            load_pls[i] = 1'b0;
        endcase
      end
      if (io_rd && data_hit && data_idx == 2'(i))
      begin
        // latched value wins over live count
        case (fmt_reg[i])
          FMT_HIGH:
          begin
            rdata_next = held_reg[i] ? latch_reg[i][15:8] : live[i][15:8];
            held_next[i] = 1'b0;
          end
          FMT_LOW_HIGH:
          begin
            rd_hi_next[i] = !rd_hi_reg[i];
            if (rd_hi_reg[i])
            begin
              rdata_next = held_reg[i] ? latch_reg[i][15:8]
                                       : live[i][15:8];
              held_next[i] = 1'b0;
            end
            else
              rdata_next = held_reg[i] ? latch_reg[i][7:0]
                                       : live[i][7:0];
          end
          default:
          begin
            rdata_next = held_reg[i] ? latch_reg[i][7:0] : live[i][7:0];
            held_next[i] = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= BYTE_ZERO;
      div_reg <= 5'h00;
      tick2_reg <= 1'b0;
      clk0_d_reg <= 1'b0;
      clk1_d_reg <= 1'b0;
      count_out0 <= 1'b1;
      count_out1 <= 1'b1;
      count_out2 <= 1'b1;
      for (int i = 0; i < NUM_COUNTERS; i++)
      begin
        fmt_reg[i] <= FMT_LOW_HIGH;
        mode_reg[i] <= MODE_RESET;
        bcd_reg[i] <= 1'b0;
        wr_hi_reg[i] <= 1'b0;
        rd_hi_reg[i] <= 1'b0;
        low_hold_reg[i] <= BYTE_ZERO;
        latch_reg[i] <= COUNT_ZERO;
        held_reg[i] <= 1'b0;
      end
    end
    else
    begin
      rdata_reg <= rdata_next;
      div_reg <= div_next;
      tick2_reg <= tick2_next;
      clk0_d_reg <= count_clk0;
      clk1_d_reg <= count_clk1;
      count_out0 <= outs[0];
      count_out1 <= outs[1];
      count_out2 <= outs[2];
      for (int i = 0; i < NUM_COUNTERS; i++)
      begin
        fmt_reg[i] <= fmt_next[i];
        mode_reg[i] <= mode_next[i];
        bcd_reg[i] <= bcd_next[i];
        wr_hi_reg[i] <= wr_hi_next[i];
        rd_hi_reg[i] <= rd_hi_next[i];
        low_hold_reg[i] <= low_hold_next[i];
        latch_reg[i] <= latch_next[i];
        held_reg[i] <= held_next[i];
      end
    end
  end

  assign io_rdata = rdata_reg;

  // one core per counter; pins and enables join through the interface
  for (genvar g = 0; g < NUM_COUNTERS; g++)
  begin : g_chan
    assign ch[g].load = load_pls[g];
    assign ch[g].load_val = load_val[g];
    assign ch[g].mode_field = mode_reg[g];
    assign ch[g].bcd = bcd_reg[g];
    assign ch[g].tick = ticks[g];
    assign ch[g].gate = gates[g];
    assign live[g] = ch[g].count;
    assign outs[g] = ch[g].out_lvl;
    down_count_core u_core (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .ch(ch[g])
    );
  end
endmodule : triple_down_counter_timer

//--- verification/down_counter_monitor.sv
`timescale 1ns/1ns
module down_counter_monitor
  import down_counter_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // bus
  input wire logic [2:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // counter pins
  input wire logic count_clk0,
  input wire logic count_clk1,
  input wire logic gate0,
  input wire logic gate1,
  input wire logic gate2,
  input wire logic count_out0,
  input wire logic count_out1,
  input wire logic count_out2
);
  logic [2:0] mode_reg [3];
  logic [1:0] clk_reg;
  logic [3:0] age0_reg;
  logic [3:0] age1_reg;
  logic data_rd;
  logic rate2;
  logic pulse2;
  assign data_rd = io_rd && io_addr inside {3'h4, 3'h5, 3'h6};
  assign rate2 = mode_reg[2][1:0] == 2'h2;
  assign pulse2 = rate2 || mode_reg[2] inside {3'h4, 3'h5};
  // mode shadow; latch commands leave the mode alone
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      mode_reg <= '{default: MODE_RESET};
      clk_reg <= 2'h0;
      age0_reg <= 4'hF;
      age1_reg <= 4'hF;
    end
    else
    begin
      clk_reg <= {count_clk1, count_clk0};
      age0_reg <= (count_clk0 && !clk_reg[0]) ? 4'h0
        : age0_reg + 4'(age0_reg != 4'hF);
      age1_reg <= (count_clk1 && !clk_reg[1]) ? 4'h0
        : age1_reg + 4'(age1_reg != 4'hF);
      if (io_wr && io_addr == OFF_COUNTER_CONTROL_WORD
          && io_wdata[5:4] != FMT_LATCH && io_wdata[7:6] != SEL_ILLEGAL)
        mode_reg[io_wdata[7:6]] <= io_wdata[3:1];
    end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // one tick of counter two is twenty reference cycles
  sequence s_low_tick;
    (!count_out2) [*8] ##12 !count_out2 ##1 count_out2;
  endsequence
  sequence s_high_tick;
    count_out2 [*8] ##12 count_out2;
  endsequence
  a_rdata_holds:
  assert property (!data_rd |=> $stable(io_rdata))
    else $error("read data moved without a data read");
  a_ctrl_write_only:
  assert property (io_rd && io_addr == 3'h7 |=> $stable(io_rdata))
    else $error("control port answered a read");
  a_reset_outs_high:
  assert property ($rose(rst_n) |-> count_out0 && count_out1 && count_out2)
    else $error("outputs not high after reset");
  a_tick_low_width:
  assert property (pulse2 && $fell(count_out2) |-> s_low_tick)
    else $error("counter two low pulse not one tick");
  a_rate_high_width:
  assert property (rate2 && $rose(count_out2) |-> s_high_tick)
    else $error("counter two high phase under one tick");
  a_gate_freezes:
  assert property ((mode_reg[0] == 3'h0 && !gate0 && !io_wr) [*6]
    |=> $stable(count_out0))
    else $error("counter zero output moved with gate low");
  a_zero_tick0:
  assert property (mode_reg[0] == 3'h0 && $rose(count_out0)
    |-> age0_reg < 4'hC)
    else $error("counter zero rose without a clock");
  a_zero_tick1:
  assert property (mode_reg[1] == 3'h0 && $rose(count_out1)
    |-> age1_reg < 4'hC)
    else $error("counter one rose without a clock");
endmodule : down_counter_monitor

bind triple_down_counter_timer down_counter_monitor monitor (
  .ref_clk, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
  .count_clk0, .count_clk1, .gate0, .gate1, .gate2,
  .count_out0, .count_out1, .count_out2
);

//--- verification/io_host_model.sv
`timescale 1ns/1ns
module io_host_model
  import down_counter_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // i/o bus
  output logic [2:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  initial
  begin
    io_addr = 3'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // released lines show the inverse, never a stale value
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge ref_clk);
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge ref_clk);
    io_rd = 1'b0;
    io_addr = ~a;
    d = io_rdata;
  endtask : rd
  task automatic cw(input logic [7:0] d);
    if (d[7:6] != SEL_ILLEGAL)
      wr(OFF_COUNTER_CONTROL_WORD, d);
  endtask : cw
  task automatic load16(input logic [2:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a, v[15:8]);
  endtask : load16
  task automatic read16(input logic [1:0] n, output logic [15:0] v);
    cw({n, 6'h00});
    rd(OFF_COUNTER0_DATA + {1'b0, n}, v[7:0]);
    rd(OFF_COUNTER0_DATA + {1'b0, n}, v[15:8]);
  endtask : read16
endmodule : io_host_model

//--- verification/triple_down_counter_timer_tb.sv
`timescale 1ns/1ns
module triple_down_counter_timer_tb
  import down_counter_pkg::*;
();
  localparam int LIMIT_CYCLES = 30000;
  logic ref_clk;
  logic rst_n;
  logic [2:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic [1:0] ext_clk;
  logic [2:0] gate;
  logic count_out0;
  logic count_out1;
  logic count_out2;
  int err_total;
  int total_checks;
  io_host_model host (.ref_clk, .io_addr, .io_wr, .io_rd, .io_wdata,
    .io_rdata);
  triple_down_counter_timer DUT (.ref_clk, .rst_n, .io_addr, .io_wr,
    .io_rd, .io_wdata, .io_rdata, .count_clk0(ext_clk[0]),
    .count_clk1(ext_clk[1]), .gate0(gate[0]), .gate1(gate[1]),
    .gate2(gate[2]), .count_out0, .count_out1, .count_out2);
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // slow external clock: two cycles high, three low
  task automatic pulse(input int which, input int n);
    repeat (n)
    begin
      @(negedge ref_clk);
      ext_clk[which] = ~ext_clk[which];
      repeat (2) @(negedge ref_clk);
      ext_clk[which] = ~ext_clk[which];
      repeat (2) @(negedge ref_clk);
    end
  endtask : pulse
  // gate level comes in as an argument, never a fixed tie
  task automatic set_gate(input int which, input logic lvl);
    gate[which] = lvl;
  endtask : set_gate
  task automatic settle_chk(input string what, input logic exp,
                            input logic [2:0] idx);
    logic [2:0] outs;
    repeat (4) @(negedge ref_clk);
    outs = {count_out2, count_out1, count_out0};
    chk(what, {15'h0, exp}, {15'h0, outs[idx]});
  endtask : settle_chk
  // low phase from a fall, then high phase; waits well past the pulse
  task automatic measure(output int lo, output int hi);
    int n;
    lo = 0;
    hi = 0;
    n = 0;
    while (count_out2 !== 1'b0 && n < 400)
    begin
      @(negedge ref_clk);
      n++;
    end
    while (count_out2 === 1'b0 && lo < 400)
    begin
      @(negedge ref_clk);
      lo++;
    end
    while (count_out2 === 1'b1 && hi < 200)
    begin
      @(negedge ref_clk);
      hi++;
    end
    repeat (70) @(negedge ref_clk);
  endtask : measure
  task automatic t_reset;
    chk("rdata", 16'h0000, {8'h00, io_rdata});
    settle_chk("out2 reset", 1'b1, 3'h2);
  endtask : t_reset
  task automatic t_event;
    logic [15:0] v;
    host.cw(8'h30);
    host.load16(OFF_COUNTER0_DATA, 16'hFFFF);
    settle_chk("out0 loaded", 1'b0, 3'h0);
    set_gate(0, 1'b1);
    pulse(0, 3);
    host.read16(2'h0, v);
    chk("count0", 16'hFFFC, v);
    host.cw(8'h00);
    pulse(0, 2);
    host.rd(OFF_COUNTER0_DATA, v[7:0]);
    host.rd(OFF_COUNTER0_DATA, v[15:8]);
    chk("latched", 16'hFFFC, v);
    set_gate(0, 1'b0);
    pulse(0, 4);
    host.read16(2'h0, v);
    chk("gated", 16'hFFFA, v);
    set_gate(0, 1'b1);
    host.load16(OFF_COUNTER0_DATA, 16'h0002);
    pulse(0, 2);
    settle_chk("out0 zero", 1'b1, 3'h0);
  endtask : t_event
  task automatic t_bcd;
    logic [15:0] v;
    host.cw(8'h31);
    host.wr(OFF_COUNTER0_DATA, 8'h55);
    host.cw(8'h31);
    host.load16(OFF_COUNTER0_DATA, 16'h0100);
    pulse(0, 1);
    host.read16(2'h0, v);
    chk("bcd", 16'h0099, v);
  endtask : t_bcd
  task automatic t_formats;
    logic [7:0] b;
    set_gate(1, 1'b1);
    host.cw(8'h50);
    host.wr(OFF_COUNTER1_DATA, 8'h03);
    settle_chk("out1 loaded", 1'b0, 3'h1);
    set_gate(1, 1'b0);
    pulse(1, 2);
    host.rd(OFF_COUNTER1_DATA, b);
    chk("frozen low byte", 16'h0003, {8'h00, b});
    set_gate(1, 1'b1);
    pulse(1, 3);
    settle_chk("out1 zero", 1'b1, 3'h1);
    host.cw(8'h60);
    host.wr(OFF_COUNTER1_DATA, 8'h02);
    host.cw(8'h40);
    host.rd(OFF_COUNTER1_DATA, b);
    chk("high byte", 16'h0002, {8'h00, b});
    host.rd(3'h3, b);
    chk("unmapped", 16'h0002, {8'h00, io_rdata});
    host.rd(OFF_COUNTER_CONTROL_WORD, b);
    chk("ctrl read", 16'h0002, {8'h00, io_rdata});
  endtask : t_formats
  task automatic t_cnt2;
    int lo;
    int hi;
    set_gate(2, 1'b1);
    host.cw(8'h9C);
    host.wr(OFF_COUNTER2_DATA, 8'h04);
    measure(lo, hi);
    chk("rate low", 16'(CNT2_DIV), 16'(lo));
    chk("rate high", 16'(3 * CNT2_DIV), 16'(hi));
    host.cw(8'h96);
    host.wr(OFF_COUNTER2_DATA, 8'h05);
    measure(lo, hi);
    chk("square low", 16'(2 * CNT2_DIV), 16'(lo));
    chk("square high", 16'(3 * CNT2_DIV), 16'(hi));
  endtask : t_cnt2
  task automatic t_strobe;
    logic [7:0] modes [3] = '{8'h98, 8'h9A, 8'h92};
    int ticks [3] = '{1, 1, 3};
    int lo;
    int hi;
    for (int i = 0; i < 3; i++)
    begin
      set_gate(2, 1'b0);
      host.cw(modes[i]);
      host.wr(OFF_COUNTER2_DATA, 8'h03);
      set_gate(2, 1'b1);
      measure(lo, hi);
      chk("strobe low", 16'(ticks[i] * CNT2_DIV), 16'(lo));
    end
  endtask : t_strobe
  initial
  begin
    err_total = 0;
    total_checks = 0;
    rst_n = 1'b0;
    ext_clk = 2'h0;
    gate = 3'h0;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    t_reset();
    t_event();
    t_bcd();
    t_formats();
    t_cnt2();
    t_strobe();
    conclude();
  end
  // cuts a hang short well beyond the expected run
  initial
  begin
    #(LIMIT_CYCLES * 50);
    err_total++;
    conclude();
  end
endmodule : triple_down_counter_timer_tb
